// *** logic/swd_pkg.sv ***
// package for the system watchdog: command codes, timing counts, carrier types
// assumes a 20 MHz reference clock
package swd_pkg;

    // =========================================================================
    // command encoding
    // =========================================================================
    localparam logic [7:0]  SWD_FUNC_CODE   = 8'hFD;
    localparam logic [7:0]  SWD_SUB_ENABLE  = 8'h01;
    localparam logic [7:0]  SWD_SUB_STROBE  = 8'h02;
    localparam logic [7:0]  SWD_SUB_DISABLE = 8'h03;
    localparam logic [15:0] SWD_KEY_VALUE   = 16'hFFFF;

    // =========================================================================
    // timing
    // =========================================================================
    localparam int unsigned SWD_CLK_HZ       = 20000000;
    localparam int unsigned SWD_TMO_MIN_MS   = 500;
    localparam int unsigned SWD_TMO_MAX_MS   = 2000;
    localparam int unsigned SWD_TMO_STEP_MS  = 500;
    localparam int unsigned SWD_TICK_CYCLES  = SWD_CLK_HZ / 1000 * SWD_TMO_STEP_MS;
    localparam int unsigned SWD_SEL_W        = 2;
    localparam logic [1:0]  SWD_SEL_RESET    = 2'h3;
    localparam int unsigned SWD_RST_PULSE    = 16;

    // =========================================================================
    // carriers
    // =========================================================================
    typedef struct packed {
        logic        valid;
        logic [7:0]  func;
        logic [7:0]  sub;
        logic [15:0] key;
    } swd_cmd_t;

    typedef struct packed {
        logic armed;
        logic expired;
    } swd_status_t;

endpackage

// *** logic/swd_decode.sv ***
// command decoder: classifies one command word into enable, strobe, disable
// assumes command comes from logic on the same clock
module swd_decode
    import swd_pkg::*;
(
    input  wire swd_cmd_t cmd,
    output logic          do_enable,
    output logic          do_strobe,
    output logic          do_disable
);
    logic func_ok;
    logic key_ok;

    // =========================================================================
    // decode
    // =========================================================================
    always_comb begin
        func_ok    = cmd.valid && (cmd.func == SWD_FUNC_CODE);
        key_ok     = (cmd.key == SWD_KEY_VALUE);
        do_enable  = func_ok && key_ok && (cmd.sub == SWD_SUB_ENABLE);
        do_strobe  = func_ok && (cmd.sub == SWD_SUB_STROBE);
        do_disable = func_ok && key_ok && (cmd.sub == SWD_SUB_DISABLE);
    end
endmodule // swd_decode

// *** logic/swd_top.sv ***
// system watchdog timer: arms on enable, restarts on strobe, disarms on disable,
// drives a system reset pulse when the selected period runs out
// assumes commands and timeout select come from logic on ref_clk
// Notes on behaviour
// - the timeout period is selectable from half a second up to two seconds.
// - an armed watchdog whose period runs out unserviced asserts a system reset.
// - function FDh, subfunction 01h with key FFFFh arms the watchdog and starts timing.
// - function FDh, subfunction 02h restarts the period of an armed watchdog.
// - function FDh, subfunction 3 disarms the watchdog so no timeout reset follows.
// - the disable command is subfunction 03h with key FFFFh.
module swd_top
    import swd_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = SWD_TICK_CYCLES,
    parameter int unsigned RST_PULSE   = SWD_RST_PULSE
)(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire swd_cmd_t          cmd,
    input  wire logic [SWD_SEL_W-1:0] tmo_sel,
    output logic                   sys_rst_n,
    output swd_status_t            status
);
    // =========================================================================
    // parameter checks
    // =========================================================================
    // pulse counter is eight bits wide, tick counter needs at least two states
    if (TICK_CYCLES < 2 || RST_PULSE < 1 || RST_PULSE > 255) begin : g_bad_params
        $error("swd_top: unsupported parameter values");
    end

    // =========================================================================
    // reset release
    // =========================================================================
    logic [1:0] rst_sync_q;
    logic       rst_ok_n;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) rst_sync_q <= 2'h0;
        else        rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_ok_n = rst_sync_q[1];

    // =========================================================================
    // command decode
    // =========================================================================
    logic do_enable;
    logic do_strobe;
    logic do_disable;
    swd_decode u_decode (
        .cmd        (cmd),
        .do_enable  (do_enable),
        .do_strobe  (do_strobe),
        .do_disable (do_disable)
    );

    // =========================================================================
    // timer state
    // =========================================================================
    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
    typedef enum logic [1:0] {SWD_IDLE, SWD_ARMED, SWD_FIRE} swd_state_t;

    swd_state_t           state_q, state_d;
    logic [TW-1:0]        tick_q, tick_d;
    logic [SWD_SEL_W:0]   step_q, step_d;
    logic [SWD_SEL_W:0]   limit_q, limit_d;
    logic [7:0]           pulse_q, pulse_d;
    logic                 expired_q, expired_d;

    always_comb begin
        state_d   = state_q;
        tick_d    = tick_q;
        step_d    = step_q;
        limit_d   = limit_q;
        pulse_d   = pulse_q;
        expired_d = expired_q;
        unique case (state_q)
            SWD_IDLE: begin
                if (do_enable) begin
                    state_d   = SWD_ARMED;
                    tick_d    = '0;
                    step_d    = '0;
                    limit_d   = {1'b0, tmo_sel} + 3'h1;
                    expired_d = 1'b0;
                end
            end
            SWD_ARMED: begin
                if (do_disable) begin
                    state_d = SWD_IDLE;
                end else if (do_strobe || do_enable) begin
                    tick_d = '0;
                    step_d = '0;
                end else if (tick_q == TW'(TICK_CYCLES - 1)) begin
                    tick_d = '0;
                    if (step_q + 3'h1 == limit_q) begin
                        state_d   = SWD_FIRE;
                        pulse_d   = 8'(RST_PULSE);
                        expired_d = 1'b1;
                    end else begin
                        step_d = step_q + 3'h1;
                    end
                end else begin
                    tick_d = tick_q + TW'(1);
                end
            end
            SWD_FIRE: begin
                if (pulse_q == 8'h01) state_d = SWD_IDLE;
                pulse_d = pulse_q - 8'h01;
            end
            default: state_d = SWD_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            state_q   <= SWD_IDLE;
            tick_q    <= '0;
            step_q    <= '0;
            limit_q   <= 3'h4;
            pulse_q   <= 8'h00;
            expired_q <= 1'b0;
        end else if (clk_en) begin
            state_q   <= state_d;
            tick_q    <= tick_d;
            step_q    <= step_d;
            limit_q   <= limit_d;
            pulse_q   <= pulse_d;
            expired_q <= expired_d;
        end
    end

    // =========================================================================
    // outputs
    // =========================================================================
    logic sys_rst_q;
    logic sys_rst_d;

    // registered so the reset line never glitches on decode
    always_comb begin
        sys_rst_d = (state_d != SWD_FIRE);
    end

    always_ff @(posedge ref_clk or negedge rst_ok_n) begin
        if (!rst_ok_n)   sys_rst_q <= 1'b1;
        else if (clk_en) sys_rst_q <= sys_rst_d;
    end
    assign sys_rst_n      = sys_rst_q;
    assign status.armed   = (state_q == SWD_ARMED);
    assign status.expired = expired_q;

    // =========================================================================
    // checks
    // =========================================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_ok_n);

    sequence s_enable;
        clk_en && do_enable && state_q == SWD_IDLE;
    endsequence

    a_enable_arms: assert property (s_enable |=> status.armed)
        else $error("enable did not arm");
    a_strobe_restarts: assert property (clk_en && status.armed && do_strobe && !do_disable
        |=> tick_q == '0 && step_q == '0)
        else $error("strobe did not restart period");
    a_disable_disarms: assert property (clk_en && status.armed && do_disable
        |=> state_q == SWD_IDLE)
        else $error("disable did not disarm");
    a_idle_no_reset: assert property (state_q == SWD_IDLE && !(clk_en && do_enable)
        |=> sys_rst_n)
        else $error("reset while disarmed");
    a_fire_reset: assert property (clk_en && state_q == SWD_ARMED && state_d == SWD_FIRE
        |=> !sys_rst_n && status.expired)
        else $error("timeout gave no reset");
    a_limit_range: assert property (status.armed |-> limit_q >= 3'h1 && limit_q <= 3'h4)
        else $error("timeout select out of range");
    a_no_key_no_enable: assert property (clk_en && state_q == SWD_IDLE && cmd.key != SWD_KEY_VALUE
        |=> state_q == SWD_IDLE)
        else $error("enable accepted without key");
    a_step_bound: assert property (status.armed |-> step_q < limit_q)
        else $error("period step overrun");
    a_enable_sel: assert property (s_enable |=> limit_q == {1'b0, $past(tmo_sel)} + 3'h1)
        else $error("period select not taken on enable");
    a_enable_clears: assert property (s_enable |=> !status.expired)
        else $error("enable left expired flag set");
    a_idle_strobe: assert property (clk_en && state_q == SWD_IDLE && !do_enable
        |=> !status.armed)
        else $error("idle command armed the watchdog");
    a_idle_no_fire: assert property (state_q == SWD_IDLE |=> state_q != SWD_FIRE)
        else $error("timeout while disarmed");

    // =========================================================================
    // checks: reset pulse
    // =========================================================================
    sequence s_fire_entry;
        clk_en && state_q == SWD_ARMED && state_d == SWD_FIRE;
    endsequence

    sequence s_pulse_last;
        clk_en && state_q == SWD_FIRE && pulse_q == 8'h01;
    endsequence

    a_pulse_start: assert property (s_fire_entry |=> pulse_q == 8'(RST_PULSE))
        else $error("pulse length not loaded");
    a_pulse_holds: assert property (state_q == SWD_FIRE && !(clk_en && pulse_q == 8'h01)
        |=> !sys_rst_n)
        else $error("reset pulse cut short");
    a_pulse_ends: assert property (s_pulse_last |=> sys_rst_n && !status.armed)
        else $error("reset pulse did not end disarmed");
    a_expired_rise: assert property ($rose(status.expired) |-> !sys_rst_n)
        else $error("expired without reset");

    // clock enable low must hold the state, tick and reset output registers
    a_frozen_state: assert property (!clk_en
        |=> $stable(state_q) && $stable(tick_q) && $stable(sys_rst_n))
        else $error("state moved while clock enable low");
endmodule // swd_top

// *** dv/swd_top_bench.sv ***
// self-checking bench for the system watchdog top level
// assumes swd_pkg compiled first; shortened tick and pulse counts
module swd_top_bench
    import swd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned TICK  = 20;
    localparam int unsigned PULSE = 4;
    logic                  ref_clk;
    logic                  rst_n;
    logic                  clk_en;
    swd_cmd_t              cmd;
    logic [SWD_SEL_W-1:0]  tmo_sel;
    logic                  sys_rst_n;
    swd_status_t           status;
    int                    num_errors = 0;
    int                    n_checks   = 0;

    swd_top #(.TICK_CYCLES(TICK), .RST_PULSE(PULSE)) dut_u (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .cmd       (cmd),
        .tmo_sel   (tmo_sel),
        .sys_rst_n (sys_rst_n),
        .status    (status)
    );

    // =========================================================================
    // helpers
    // =========================================================================
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    // one command word, valid for exactly one rising edge
    task automatic send(input logic [7:0] f, input logic [7:0] s, input logic [15:0] k);
        @(negedge ref_clk);
        cmd = '{valid: 1'b1, func: f, sub: s, key: k};
        @(negedge ref_clk);
        cmd = '0;
    endtask
    task automatic quiet(input int cyc);
        int lows = 0;
        repeat (cyc) begin
            @(negedge ref_clk);
            if (sys_rst_n !== 1'b1) lows++;
        end
        chk(lows, 0, "system reset while not due");
    endtask
    // counts cycles to the reset pulse, then its length
    task automatic expire(input int nom);
        int n = 0;
        int m = 0;
        while (sys_rst_n === 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 400) begin
            num_errors++;
            $display("Error at %0t: reset pulse never came", $time);
            results();
        end else begin
            chk(n >= nom - 1 && n <= nom + 1, 1'b1, "timeout length");
            chk(status.expired, 1'b1, "expired flag on timeout");
            while (sys_rst_n === 1'b0 && m < 50) begin
                @(negedge ref_clk);
                m++;
            end
            chk(m, PULSE, "reset pulse length");
            chk(status.armed, 1'b0, "disarmed after pulse");
        end
    endtask

    // =========================================================================
    // scenarios
    // =========================================================================
    task automatic t_idle();
        chk(status.armed, 1'b0, "armed after reset");
        chk(status.expired, 1'b0, "expired after reset");
        send(SWD_FUNC_CODE, SWD_SUB_STROBE, SWD_KEY_VALUE);
        send(SWD_FUNC_CODE, SWD_SUB_DISABLE, SWD_KEY_VALUE);
        quiet(100);
        chk(status.armed, 1'b0, "idle strobe arms");
        $display("test idle done");
    endtask
    task automatic t_periods();
        for (int sel = 0; sel < 4; sel++) begin
            tmo_sel = sel[1:0];
            send(SWD_FUNC_CODE, SWD_SUB_ENABLE, SWD_KEY_VALUE);
            chk(status.armed, 1'b1, "enable arms");
            chk(status.expired, 1'b0, "enable clears expired");
            expire((sel + 1) * TICK);
        end
        $display("test periods done");
    endtask
    task automatic t_strobe();
        tmo_sel = 2'h0;
        send(SWD_FUNC_CODE, SWD_SUB_ENABLE, SWD_KEY_VALUE);
        for (int i = 0; i < 5; i++) begin
            quiet(12);
            // enable while armed serves as a strobe
            if (i == 2) send(SWD_FUNC_CODE, SWD_SUB_ENABLE, SWD_KEY_VALUE);
            else send(SWD_FUNC_CODE, SWD_SUB_STROBE, 16'h0FFF);
        end
        chk(status.armed, 1'b1, "armed while strobed");
        expire(TICK);
        send(SWD_FUNC_CODE, SWD_SUB_ENABLE, SWD_KEY_VALUE);
        clk_en = 1'b0;
        quiet(40);
        clk_en = 1'b1;
        expire(TICK);
        $display("test strobe done");
    endtask
    task automatic t_disable();
        tmo_sel = 2'h3;
        send(SWD_FUNC_CODE, SWD_SUB_ENABLE, SWD_KEY_VALUE);
        quiet(10);
        send(SWD_FUNC_CODE, SWD_SUB_DISABLE, 16'hFFFE);
        chk(status.armed, 1'b1, "disable with bad key");
        send(SWD_FUNC_CODE, SWD_SUB_DISABLE, SWD_KEY_VALUE);
        chk(status.armed, 1'b0, "disable disarms");
        quiet(200);
        send(SWD_FUNC_CODE, SWD_SUB_ENABLE, 16'hFFFE);
        send(8'hFC, SWD_SUB_ENABLE, SWD_KEY_VALUE);
        send(SWD_FUNC_CODE, 8'h04, SWD_KEY_VALUE);
        chk(status.armed, 1'b0, "malformed enable arms");
        quiet(100);
        $display("test disable done");
    endtask

    initial begin
        rst_n   = 1'b0;
        clk_en  = 1'b1;
        cmd     = '0;
        tmo_sel = '0;
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        t_idle();
        t_periods();
        t_strobe();
        t_disable();
        results();
    end
endmodule // swd_top_bench
